// ===== dv/debug_port_key_programming_access_tb.sv
/*
  Self-checking bench for the access layer.
  Assumes the checker is bound and the NVM sink model sits on the copy port.
*/
`timescale 1ns/1ps
`default_nettype none

module debug_port_key_programming_access_tb;
  logic                  clk_sys = 1'b0, rstn = 1'b0, keyStart = 1'b0, keyByteValid = 1'b0;
  logic [7:0]            keyByte = 8'h00, v, csRdData, linkCtlA, linkCtlB;
  dpk_pkg::dpk_cs_req_t  csReq = '0;
  dpk_pkg::dpk_bus_req_t busReq = '0;
  logic                  syncActive = 1'b0, syncPin = 1'b0, sysLocked = 1'b0, sysSleeping = 1'b0;
  logic                  sysClkStopped = 1'b0, csRdValid, busGo, busRefuse, syncEvent, sysResetOut;
  logic                  sysClkHold, nvmSessionOut, urowSessionOut, rowCopyValid, rowCopyReady, orderBad;
  logic [1:0]            portClkSel;
  logic [4:0]            rowCopyIdx;
  logic [5:0]            nTaken;
  int                    n_mismatch = 0, tests_run = 0, cycles = 0;

  always #5 clk_sys = ~clk_sys;

  dpk_access_layer dut_u (.clk_sys(clk_sys), .rstn(rstn), .csReq(csReq), .csRdData(csRdData),
    .csRdValid(csRdValid), .keyStart(keyStart), .keyByteValid(keyByteValid), .keyByte(keyByte),
    .errValid(1'b0), .errCode(3'h0), .busReq(busReq), .busGo(busGo), .busRefuse(busRefuse),
    .syncActive(syncActive), .syncPin(syncPin), .syncEvent(syncEvent), .sysLocked(sysLocked),
    .sysSleeping(sysSleeping), .sysClkStopped(sysClkStopped), .memCheckStatus(3'h0),
    .sysResetOut(sysResetOut), .sysClkHold(sysClkHold), .nvmSessionOut(nvmSessionOut),
    .urowSessionOut(urowSessionOut), .linkCtlA(linkCtlA), .linkCtlB(linkCtlB), .portClkSel(portClkSel),
    .rowCopyValid(rowCopyValid), .rowCopyIdx(rowCopyIdx), .rowCopyReady(rowCopyReady));
  dpk_nvm_sink sink_u (.clk_sys(clk_sys), .rstn(rstn), .rowCopyValid(rowCopyValid),
    .rowCopyIdx(rowCopyIdx), .rowCopyReady(rowCopyReady), .nTaken(nTaken), .orderBad(orderBad));

  // Expected system state byte
  function automatic logic [7:0] exp_state(logic r, logic s, logic n, logic u, logic l);
    return {2'b00, r, s, n, u, 1'b0, l};
  endfunction

  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Strobes rise and fall on falling edges, one cycle wide
  task automatic cs_wr(logic [3:0] a, logic [7:0] d);
    @(negedge clk_sys);
    csReq <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk_sys);
    csReq <= '0;
  endtask

  // Read data is taken only with its valid pulse
  task automatic rchk(logic [3:0] a, logic [7:0] exp);
    @(negedge clk_sys);
    csReq <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    csReq <= '0;
    chk($sformatf("register %h", a), csRdValid === 1'b1 ? csRdData : 8'hXX, exp);
  endtask

  task automatic send_key(logic [63:0] k);
    @(negedge clk_sys);
    keyStart <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      keyStart <= 1'b0;
      keyByteValid <= 1'b1;
      keyByte <= k[8*i +: 8];
    end
    @(negedge clk_sys);
    keyByteValid <= 1'b0;
  endtask

  task automatic bus_chk(logic wr, logic ram, logic [15:0] a, logic expGo);
    @(negedge clk_sys);
    busReq <= '{req: 1'b1, write: wr, isRam: ram, addr: a};
    @(negedge clk_sys);
    busReq <= '0;
    chk("bus answer", {6'h00, busGo, busRefuse}, expGo ? 8'h02 : 8'h01);
  endtask

  // Release value other than the signature
  task automatic release_rst();
    v = 8'($urandom);
    if (v == dpk_pkg::RESET_SIGNATURE) v = 8'h00;
    cs_wr(dpk_pkg::REG_RESET_REQUEST_FIELD, v);
  endtask

  // Hang guard well above the expected run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(32'h393bc9ae));
    repeat (6) @(negedge clk_sys);
    rstn <= 1'b1;
    // Registers reachable asleep with the clock stopped
    sysSleeping = 1'b1;
    sysClkStopped = 1'b1;
    rchk(dpk_pkg::REG_REVISION, dpk_pkg::REVISION_VALUE);
    rchk(4'h5, 8'h00);
    rchk(dpk_pkg::REG_SYSCTL, 8'h01);
    rchk(dpk_pkg::REG_SYSSTATE, exp_state(0, 1, 0, 0, 0));
    bus_chk(1'b1, 1'b1, 16'h0010, 1'b1);
    cs_wr(dpk_pkg::REG_SYSCTL, 8'h00);
    bus_chk(1'b0, 1'b0, 16'($urandom), 1'b0);
    cs_wr(dpk_pkg::REG_SYSCTL, 8'h01);
    sysSleeping = 1'b0;
    sysClkStopped = 1'b0;
    rchk(dpk_pkg::REG_SYSSTATE, exp_state(0, 0, 0, 0, 0));
    v = 8'($urandom);
    cs_wr(dpk_pkg::REG_LINKCTLA, v);
    cs_wr(dpk_pkg::REG_CLKCTL, v);
    chk("link control", linkCtlA, v & dpk_pkg::LINKCTLA_MASK);
    chk("clock select", {6'h00, portClkSel}, {6'h00, v[1:0]});
    // NVM session on an open part; one flipped key bit first
    send_key(dpk_pkg::KEY_NVM ^ (64'h1 << ($urandom % 64)));
    rchk(dpk_pkg::REG_KEYSTAT, 8'h00);
    send_key(dpk_pkg::KEY_ERASE);
    rchk(dpk_pkg::REG_KEYSTAT, 8'h08);
    send_key(dpk_pkg::KEY_NVM);
    rchk(dpk_pkg::REG_KEYSTAT, 8'h18);
    cs_wr(dpk_pkg::REG_RESET_REQUEST_FIELD, dpk_pkg::RESET_SIGNATURE);
    rchk(dpk_pkg::REG_SYSSTATE, exp_state(1, 0, 0, 0, 0));
    bus_chk(1'b1, 1'b0, 16'($urandom), 1'b0);
    release_rst();
    rchk(dpk_pkg::REG_SYSSTATE, exp_state(0, 0, 1, 0, 0));
    rchk(dpk_pkg::REG_KEYSTAT, 8'h00);
    bus_chk(1'b1, 1'b0, 16'($urandom), 1'b1);
    cs_wr(dpk_pkg::REG_RESET_REQUEST_FIELD, dpk_pkg::RESET_SIGNATURE);
    cs_wr(dpk_pkg::REG_RESET_REQUEST_FIELD, 8'h00);
    rchk(dpk_pkg::REG_SYSSTATE, exp_state(0, 0, 0, 0, 0));
    // Port disable drops keys and forces the clock hold
    send_key(dpk_pkg::KEY_NVM);
    cs_wr(dpk_pkg::REG_LINKCTLB, 8'h04);
    cs_wr(dpk_pkg::REG_SYSCTL, 8'h00);
    rchk(dpk_pkg::REG_SYSCTL, 8'h01);
    rchk(dpk_pkg::REG_KEYSTAT, 8'h00);
    cs_wr(dpk_pkg::REG_LINKCTLB, 8'h00);
    // User row session on a locked part
    sysLocked = 1'b1;
    bus_chk(1'b1, 1'b1, 16'h0000, 1'b0);
    send_key(dpk_pkg::KEY_UROW);
    rchk(dpk_pkg::REG_KEYSTAT, 8'h20);
    cs_wr(dpk_pkg::REG_RESET_REQUEST_FIELD, dpk_pkg::RESET_SIGNATURE);
    release_rst();
    rchk(dpk_pkg::REG_SYSSTATE, exp_state(0, 0, 0, 1, 1));
    bus_chk(1'b1, 1'b1, 16'h001F, 1'b1);
    bus_chk(1'b1, 1'b1, 16'h0020, 1'b0);
    bus_chk(1'b1, 1'b1, 16'h0020 | 16'($urandom), 1'b0);
    bus_chk(1'b0, 1'b1, 16'($urandom % 32), 1'b0);
    cs_wr(dpk_pkg::REG_SYSCTL, 8'h03);
    for (int i = 0; i < 400 && urowSessionOut !== 1'b0; i++) @(negedge clk_sys);
    chk("bytes copied", {2'b00, nTaken}, 8'h20);
    chk("copy order", {7'h00, orderBad}, 8'h00);
    rchk(dpk_pkg::REG_SYSSTATE, exp_state(0, 0, 0, 0, 1));
    cs_wr(dpk_pkg::REG_KEYSTAT, 8'h20);
    rchk(dpk_pkg::REG_KEYSTAT, 8'h00);
    cs_wr(dpk_pkg::REG_RESET_REQUEST_FIELD, dpk_pkg::RESET_SIGNATURE);
    cs_wr(dpk_pkg::REG_RESET_REQUEST_FIELD, 8'h00);
    rchk(dpk_pkg::REG_SYSSTATE, exp_state(0, 0, 0, 0, 1));
    // Sync event has no enable, so random pin activity must show
    for (int i = 0; i < 16; i++) begin
      {syncActive, syncPin} = 2'($urandom);
      @(negedge clk_sys);
      chk("sync event", {7'h00, syncEvent}, {7'h00, syncActive & syncPin});
    end
    tally_and_finish();
  end
endmodule // debug_port_key_programming_access_tb

`default_nettype wire

// ===== dv/dpk_access_props.sv
/*
  Port-level assertions for the debug port access layer.
  Assumes the bind below and the port list of dpk_access_layer.
*/
`timescale 1ns/1ps
`default_nettype none

module dpk_access_props (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rstn,
  // Physical layer side
  input wire dpk_pkg::dpk_cs_req_t  csReq,
  input wire dpk_pkg::dpk_bus_req_t busReq,
  input wire logic                  busGo,
  input wire logic                  busRefuse,
  input wire logic                  syncActive,
  input wire logic                  syncPin,
  input wire logic                  syncEvent,
  // System side
  input wire logic                  sysLocked,
  input wire logic                  sysResetOut,
  input wire logic                  sysClkStopped,
  input wire logic                  sysClkHold,
  input wire logic                  nvmSessionOut,
  input wire logic                  urowSessionOut,
  input wire logic [7:0]            linkCtlB,
  // User row copy
  input wire logic                  rowCopyValid,
  input wire logic [4:0]            rowCopyIdx,
  input wire logic                  rowCopyReady
);
  // One domain, so one clock and one disable
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sync_level_a: assert property ($past(rstn) |-> syncEvent == $past(syncActive & syncPin))
    else $error("sync event does not follow the pin");
  reset_sig_a: assert property ($past(rstn) && $past(csReq.wr) && $past(csReq.addr) == dpk_pkg::REG_RESET_REQUEST_FIELD
    && !$past(linkCtlB[2]) |-> sysResetOut == ($past(csReq.wdata) == dpk_pkg::RESET_SIGNATURE))
    else $error("reset output does not match the request written");
  stopped_clock_a: assert property (busReq.req && sysClkStopped && !sysClkHold |=> busRefuse && !busGo)
    else $error("bus access taken with the clock stopped");
  held_clock_a: assert property (busReq.req && sysClkHold && !sysResetOut && !sysLocked
    && !urowSessionOut |=> busGo && !busRefuse)
    else $error("bus access refused on an open device");
  ram_window_a: assert property (busReq.req && busReq.write && busReq.isRam && busReq.addr >= 16'h0020
    && urowSessionOut |=> busRefuse && !busGo)
    else $error("write outside the buffer went ahead");
  ram_read_a: assert property (busReq.req && !busReq.write && busReq.isRam && urowSessionOut |=> busRefuse)
    else $error("ram read allowed in user row session");
  copy_step_a: assert property (rowCopyValid && rowCopyReady && rowCopyIdx != 5'h1F
    |=> rowCopyValid && rowCopyIdx == $past(rowCopyIdx) + 5'h01)
    else $error("copy offset did not advance by one");
  copy_hold_a: assert property (rowCopyValid && !rowCopyReady |=> rowCopyValid && $stable(rowCopyIdx))
    else $error("copy offer dropped while stalled");
  copy_end_a: assert property (rowCopyValid && rowCopyReady && rowCopyIdx == 5'h1F |-> ##[1:2] !urowSessionOut)
    else $error("user row session still set after the copy");
  nvm_start_a: assert property ($rose(nvmSessionOut) |-> $past(sysResetOut) && !sysResetOut)
    else $error("nvm session began outside a reset release");
  urow_start_a: assert property ($rose(urowSessionOut) |-> $past(sysResetOut) && $past(sysLocked))
    else $error("user row session began outside a locked release");
endmodule // dpk_access_props

bind dpk_access_layer dpk_access_props props_u (
  .clk_sys(clk_sys), .rstn(rstn), .csReq(csReq), .busReq(busReq), .busGo(busGo), .busRefuse(busRefuse),
  .syncActive(syncActive), .syncPin(syncPin), .syncEvent(syncEvent), .sysLocked(sysLocked),
  .sysResetOut(sysResetOut), .sysClkStopped(sysClkStopped), .sysClkHold(sysClkHold),
  .nvmSessionOut(nvmSessionOut), .urowSessionOut(urowSessionOut), .linkCtlB(linkCtlB),
  .rowCopyValid(rowCopyValid), .rowCopyIdx(rowCopyIdx), .rowCopyReady(rowCopyReady)
);

`default_nettype wire

// ===== dv/dpk_nvm_sink.sv
/*
  Model of the NVM side taking the user row copy, with random stalls.
  Assumes offers arrive in order from offset zero after each reset.
*/
`timescale 1ns/1ps
`default_nettype none

module dpk_nvm_sink (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Copy offer
  input  wire logic       rowCopyValid,
  input  wire logic [4:0] rowCopyIdx,
  output var  logic       rowCopyReady,
  // Record for the bench
  output var  logic [5:0] nTaken,
  output var  logic       orderBad
);
  initial rowCopyReady = 1'b0;
  // Stall about a third of the time so the offer must hold
  always @(negedge clk_sys) begin
    rowCopyReady <= ($urandom % 3) != 0;
  end
  // Count accepted bytes, flag any out of sequence
  always @(posedge clk_sys) begin
    if (!rstn) begin
      nTaken <= 6'h00;
      orderBad <= 1'b0;
    end else if (rowCopyValid && rowCopyReady) begin
      if (rowCopyIdx != nTaken[4:0]) orderBad <= 1'b1;
      nTaken <= nTaken + 6'h01;
    end
  end
endmodule // dpk_nvm_sink

`default_nettype wire

// ===== hw/dpk_access_layer.sv
/*
  Access layer of the single-wire debug port: key entry and decode, system
  reset request, NVM and user-row programming sessions, user-row copy,
  sync-character event, system clock hold and the port's register map.
  Assumes the physical layer delivers control accesses, key bytes and memory
  requests as one-cycle strobes on clk_sys, already synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Unlocked device lets programmer write NVM controller or flash through the port.
// - Device sets NVM session flag once active; programmer polls it before writing.
// - Locked user-row flow: key, reset request and release, poll session flag.
// - In a user-row session only RAM writes below byte 32 execute.
// - At session end the 32-byte buffer copies one to one into the user row.
// - Device clears the user-row session flag when the copy finishes.
// - Every RAM read through the port is refused in user-row mode.
// - Sync character pin level, while a sync character runs, gives a level event on clk_sys, always on.
// - The port takes no event inputs; it only generates events.
// - Physical layer keeps working in every sleep mode.
// - Clock stopped by sleep without hold blocks all system-bus accesses.
// - Clock hold keeps system clock running in sleep so bus access works.
// - Clock hold bit reads one by default whenever the port is enabled.
// - System state shows whether the system domain is sleeping.
// - Keys are 64 bits, LSB first; only an exact match is decoded.
// - Starting the NVM session clears its key flag and sets the session flag.
module dpk_access_layer (
  // Clock and reset
  input  wire  logic                  clk_sys,
  input  wire  logic                  rstn,
  // Control space access from the physical layer
  input  wire  dpk_pkg::dpk_cs_req_t  csReq,
  output logic [7:0]                  csRdData,
  output logic                        csRdValid,
  // Key bytes from the physical layer
  input  wire  logic                  keyStart,
  input  wire  logic                  keyByteValid,
  input  wire  logic [7:0]            keyByte,
  // Error signature from the physical layer
  input  wire  logic                  errValid,
  input  wire  logic [2:0]            errCode,
  // Memory access requests from the physical layer
  input  wire  dpk_pkg::dpk_bus_req_t busReq,
  output logic                        busGo,
  output logic                        busRefuse,
  // Sync character from the physical layer
  input  wire  logic                  syncActive,
  input  wire  logic                  syncPin,
  output logic                        syncEvent,
  // System side status
  input  wire  logic                  sysLocked,
  input  wire  logic                  sysSleeping,
  input  wire  logic                  sysClkStopped,
  input  wire  logic [2:0]            memCheckStatus,
  // System side control
  output logic                        sysResetOut,
  output logic                        sysClkHold,
  output logic                        nvmSessionOut,
  output logic                        urowSessionOut,
  // Link configuration to the physical layer
  output logic [7:0]                  linkCtlA,
  output logic [7:0]                  linkCtlB,
  output logic [1:0]                  portClkSel,
  // User row copy to the NVM controller
  output logic                        rowCopyValid,
  output logic [4:0]                  rowCopyIdx,
  input  wire  logic                  rowCopyReady
);

  dpk_pkg::dpk_state_t st_r;
  dpk_pkg::dpk_state_t st_nxt;

  // Exact 64-bit key compare, used for each of the three keys
  function automatic logic keyMatch(input logic [63:0] got, input logic [63:0] want);
    keyMatch = (got == want);
  endfunction

  // Byte in a register field, used on the key status, system control and system state reads
  function automatic logic [7:0] bitAt(input logic val, input int pos);
    bitAt = 8'h00;
    bitAt[pos] = val;
  endfunction

  logic portOff;
  logic rstActive;
  logic keyLast;
  logic relWrite;
  logic busClkOk;
  logic ramWinOk;
  logic [63:0] keyFull;
  logic [7:0]  rdMux;

  // Helper terms shared by the next-state logic
  always_comb begin
    // Disable works as a port reset
    portOff   = st_r.linkCtlB[dpk_pkg::LINKCTLB_DIS];
    rstActive = (st_r.reset_request_field == dpk_pkg::RESET_SIGNATURE);
    // Clock gone in sleep without hold means no bus at all
    busClkOk  = !sysClkStopped || st_r.clkHold;
    ramWinOk  = (busReq.addr < dpk_pkg::UROW_BUF_SIZE);
    // New byte enters at the top; after eight bytes the first sits lowest
    keyFull   = {keyByte, st_r.keyShift[63:8]};

    // Eighth key byte lands this cycle
    keyLast   = keyByteValid && !keyStart && st_r.keyCount == dpk_pkg::KEY_BYTES - 4'h1;
    // Release write
    relWrite  = rstActive && csReq.wr && csReq.addr == dpk_pkg::REG_RESET_REQUEST_FIELD
                && csReq.wdata != dpk_pkg::RESET_SIGNATURE;
  end

  // Register read multiplexer
  always_comb begin
    case (csReq.addr)
      dpk_pkg::REG_REVISION: rdMux = dpk_pkg::REVISION_VALUE;
      dpk_pkg::REG_ERRSIG:   rdMux = {5'h00, st_r.errSig};
      dpk_pkg::REG_LINKCTLA: rdMux = st_r.linkCtlA;
      dpk_pkg::REG_LINKCTLB: rdMux = st_r.linkCtlB;
      dpk_pkg::REG_KEYSTAT:  rdMux = bitAt(st_r.keyUrow, dpk_pkg::KEY_UROW_BIT)
                                   | bitAt(st_r.keyNvm, dpk_pkg::KEY_NVM_BIT)
                                   | bitAt(st_r.keyErase, dpk_pkg::KEY_ERASE_BIT);
      dpk_pkg::REG_RESET_REQUEST_FIELD:   rdMux = st_r.reset_request_field;
      dpk_pkg::REG_CLKCTL:   rdMux = {6'h00, st_r.clkSel};
      dpk_pkg::REG_SYSCTL:   rdMux = bitAt(st_r.urowFinal, dpk_pkg::SYSCTL_FINAL)
                                   | bitAt(st_r.clkHold, dpk_pkg::SYSCTL_CLKHOLD);
      dpk_pkg::REG_SYSSTATE: rdMux = bitAt(rstActive, dpk_pkg::STATE_SYSTEM_RESET_ACTIVE)
                                   | bitAt(sysSleeping, dpk_pkg::STATE_SLEEPING)
                                   | bitAt(st_r.nvmSess, dpk_pkg::STATE_NVMSESS)
                                   | bitAt(st_r.urowSess, dpk_pkg::STATE_UROWSESS)
                                   | bitAt(sysLocked, dpk_pkg::STATE_LOCKED);
      dpk_pkg::REG_MEMCHECK: rdMux = {5'h00, memCheckStatus};
      default:               rdMux = 8'h00;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdValid   = 1'b0;
    st_nxt.busGo     = 1'b0;
    st_nxt.busRefuse = 1'b0;

    // Register read; error signature clears on read, a new error wins
    if (csReq.rd) begin
      st_nxt.rdData  = rdMux;
      st_nxt.rdValid = 1'b1;
      if (csReq.addr == dpk_pkg::REG_ERRSIG) begin
        st_nxt.errSig = 3'h0;
      end
    end

    if (errValid) begin
      st_nxt.errSig = errCode;
    end

    // Register writes
    if (csReq.wr) begin
      case (csReq.addr)
        dpk_pkg::REG_LINKCTLA: begin
          // Unused bit 6 always reads zero
          st_nxt.linkCtlA = csReq.wdata & dpk_pkg::LINKCTLA_MASK;
        end
        dpk_pkg::REG_LINKCTLB: begin
          st_nxt.linkCtlB = csReq.wdata & dpk_pkg::LINKCTLB_MASK;
        end
        dpk_pkg::REG_KEYSTAT: begin
          // Writing one to the user-row key flag closes that key
          if (csReq.wdata[dpk_pkg::KEY_UROW_BIT]) begin
            st_nxt.keyUrow = 1'b0;
          end
        end
        dpk_pkg::REG_RESET_REQUEST_FIELD: begin
          // Only the exact signature holds the system in reset
          if (csReq.wdata == dpk_pkg::RESET_SIGNATURE) begin
            st_nxt.reset_request_field = dpk_pkg::RESET_SIGNATURE;
          end else begin
            st_nxt.reset_request_field = csReq.wdata;
          end
        end
        dpk_pkg::REG_CLKCTL: begin
          st_nxt.clkSel = csReq.wdata[1:0];
        end
        dpk_pkg::REG_SYSCTL: begin
          st_nxt.clkHold   = csReq.wdata[dpk_pkg::SYSCTL_CLKHOLD];
          st_nxt.urowFinal = csReq.wdata[dpk_pkg::SYSCTL_FINAL];
          // Data-complete starts the copy only inside a user-row session
          if (csReq.wdata[dpk_pkg::SYSCTL_FINAL] && st_r.urowSess
              && st_r.copyState == dpk_pkg::DPK_COPY_IDLE) begin
            st_nxt.copyState = dpk_pkg::DPK_COPY_RUN;
            st_nxt.copyIdx   = 5'h00;
          end
        end
        default: ;
      endcase
    end

    // Key shifting and exact decode
    if (keyStart) begin
      st_nxt.keyCount = 4'h0;
    end else if (keyByteValid && st_r.keyCount != dpk_pkg::KEY_BYTES) begin
      // Bytes past the eighth wait for a new start
      st_nxt.keyShift = keyFull;
      st_nxt.keyCount = st_r.keyCount + 4'h1;
      if (keyLast) begin
        if (keyMatch(keyFull, dpk_pkg::KEY_ERASE)) begin
          st_nxt.keyErase = 1'b1;
        end
        if (keyMatch(keyFull, dpk_pkg::KEY_NVM)) begin
          st_nxt.keyNvm = 1'b1;
        end
        if (keyMatch(keyFull, dpk_pkg::KEY_UROW)) begin
          st_nxt.keyUrow = 1'b1;
        end
      end
    end

    // Reset release: start or end a session
    if (relWrite) begin
      if (st_r.nvmSess) begin
        st_nxt.nvmSess = 1'b0;
      end else if (st_r.keyNvm && !sysLocked) begin
        st_nxt.nvmSess = 1'b1;
        // Old key used up; one completing now is kept
        st_nxt.keyNvm  = keyLast && keyMatch(keyFull, dpk_pkg::KEY_NVM);
      end
      if (st_r.keyUrow && sysLocked && !st_r.urowSess) begin
        st_nxt.urowSess = 1'b1;
      end
      // Erase key is consumed by the reset; a new one wins
      st_nxt.keyErase = keyLast && keyMatch(keyFull, dpk_pkg::KEY_ERASE);
    end

    // User row copy, one byte per accepted handshake, same offset
    case (st_r.copyState)
      dpk_pkg::DPK_COPY_IDLE: ;
      dpk_pkg::DPK_COPY_RUN: begin
        // Stalls hold the offer
        if (rowCopyReady) begin
          if (st_r.copyIdx == dpk_pkg::UROW_LAST_IDX) begin
            st_nxt.copyState = dpk_pkg::DPK_COPY_END;
          end else begin
            st_nxt.copyIdx = st_r.copyIdx + 5'h01;
          end
        end
      end
      dpk_pkg::DPK_COPY_END: begin
        st_nxt.urowSess  = 1'b0;
        // A data-complete write in this cycle wins
        if (!(csReq.wr && csReq.addr == dpk_pkg::REG_SYSCTL)) begin
          st_nxt.urowFinal = 1'b0;
        end
        st_nxt.copyState = dpk_pkg::DPK_COPY_IDLE;
      end
      default: begin
        st_nxt.copyState = dpk_pkg::DPK_COPY_IDLE;
      end
    endcase

    // Memory access gate
    if (busReq.req) begin
      // Reset held or no clock
      if (!busClkOk || rstActive) begin
        st_nxt.busRefuse = 1'b1;
      end else if (st_r.urowSess) begin
        // Only RAM writes inside the buffer window go through
        if (busReq.isRam && busReq.write && ramWinOk && st_r.copyState == dpk_pkg::DPK_COPY_IDLE) begin
          st_nxt.busGo = 1'b1;
        end else begin
          st_nxt.busRefuse = 1'b1;
        end
      end else if (sysLocked) begin
        st_nxt.busRefuse = 1'b1;
      end else begin
        // Unlocked: direct NVM and flash writes are allowed
        st_nxt.busGo = 1'b1;
      end
    end

    // Sync event follows the pin while a sync character runs; no disable
    st_nxt.syncEvent = syncActive && syncPin;

    // Port disable drops keys and sessions and restores the clock hold
    if (portOff) begin
      st_nxt.keyErase  = 1'b0;
      st_nxt.keyNvm    = 1'b0;
      st_nxt.keyUrow   = 1'b0;
      st_nxt.keyCount  = 4'h0;
      st_nxt.nvmSess   = 1'b0;
      st_nxt.urowSess  = 1'b0;
      st_nxt.clkHold   = 1'b1;
      st_nxt.copyState = dpk_pkg::DPK_COPY_IDLE;
      st_nxt.reset_request_field    = dpk_pkg::RESET_REQUEST_FIELD_RESET;
      st_nxt.linkCtlA  = dpk_pkg::LINKCTLA_RESET;
      st_nxt.linkCtlB  = (csReq.wr && csReq.addr == dpk_pkg::REG_LINKCTLB)
                       ? (csReq.wdata & dpk_pkg::LINKCTLB_MASK) : st_r.linkCtlB;
    end
  end

  // State register; the port runs regardless of system sleep
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_r           <= '0;
      st_r.linkCtlA  <= dpk_pkg::LINKCTLA_RESET;
      st_r.linkCtlB  <= dpk_pkg::LINKCTLB_RESET;
      st_r.reset_request_field    <= dpk_pkg::RESET_REQUEST_FIELD_RESET;
      st_r.clkSel    <= dpk_pkg::CLKSEL_RESET;
      st_r.clkHold   <= 1'b1;
      st_r.copyState <= dpk_pkg::DPK_COPY_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops, sysResetOut decoded from the reset request field; no event inputs exist
  assign csRdData       = st_r.rdData;
  assign csRdValid      = st_r.rdValid;
  assign busGo          = st_r.busGo;
  assign busRefuse      = st_r.busRefuse;
  assign syncEvent      = st_r.syncEvent;
  assign sysResetOut    = rstActive;
  assign sysClkHold     = st_r.clkHold;
  assign nvmSessionOut  = st_r.nvmSess;
  assign urowSessionOut = st_r.urowSess;
  assign linkCtlA       = st_r.linkCtlA;
  assign linkCtlB       = st_r.linkCtlB;
  assign portClkSel     = st_r.clkSel;

  // Copy port; valid decodes the copy state flops
  assign rowCopyValid   = (st_r.copyState == dpk_pkg::DPK_COPY_RUN);
  assign rowCopyIdx     = st_r.copyIdx;

endmodule // dpk_access_layer

`default_nettype wire

// ===== hw/dpk_pkg.sv
/*
  Package for the debug port key and access layer block: register map,
  field positions, reset values, key signatures, states and carrier structs.
  Assumes one 8-bit register space reached by the port's own control access.
*/
`default_nettype none

package dpk_pkg;

  // Register indices in the port's control space
  localparam logic [3:0] REG_REVISION   = 4'h0;
  localparam logic [3:0] REG_ERRSIG     = 4'h1;
  localparam logic [3:0] REG_LINKCTLA   = 4'h2;
  localparam logic [3:0] REG_LINKCTLB   = 4'h3;
  localparam logic [3:0] REG_KEYSTAT    = 4'h7;
  localparam logic [3:0] REG_RESET_REQUEST_FIELD     = 4'h8;
  localparam logic [3:0] REG_CLKCTL     = 4'h9;
  localparam logic [3:0] REG_SYSCTL     = 4'hA;
  localparam logic [3:0] REG_SYSSTATE   = 4'hB;
  localparam logic [3:0] REG_MEMCHECK   = 4'hC;

  // Reset values
  localparam logic [7:0] REVISION_VALUE = 8'h30;
  localparam logic [7:0] LINKCTLA_RESET = 8'h00;
  localparam logic [7:0] LINKCTLB_RESET = 8'h00;
  localparam logic [7:0] RESET_REQUEST_FIELD_RESET   = 8'h00;
  localparam logic [1:0] CLKSEL_RESET   = 2'h0;

  // Field positions
  localparam int KEY_UROW_BIT    = 5;
  localparam int KEY_NVM_BIT     = 4;
  localparam int KEY_ERASE_BIT   = 3;
  localparam int SYSCTL_FINAL    = 1;
  localparam int SYSCTL_CLKHOLD  = 0;
  localparam int STATE_SYSTEM_RESET_ACTIVE    = 5;
  localparam int STATE_SLEEPING  = 4;
  localparam int STATE_NVMSESS   = 3;
  localparam int STATE_UROWSESS  = 2;
  localparam int STATE_LOCKED    = 0;
  localparam int LINKCTLB_DIS    = 2;
  localparam logic [7:0] LINKCTLA_MASK = 8'hBF;
  localparam logic [7:0] LINKCTLB_MASK = 8'h1C;

  // Reset request signature: any other value releases the system reset
  localparam logic [7:0] RESET_SIGNATURE = 8'h59;

  // Key signatures, least significant byte shifted in first
  localparam logic [63:0] KEY_ERASE = 64'h4E564D4572617365;
  localparam logic [63:0] KEY_NVM   = 64'h4E564D50726F6720;
  localparam logic [63:0] KEY_UROW  = 64'h4E564D5573267465;
  localparam logic [3:0]  KEY_BYTES = 4'h8;

  // User row buffer window in RAM
  localparam logic [15:0] UROW_BUF_SIZE = 16'h0020;
  localparam logic [4:0]  UROW_LAST_IDX = 5'h1F;

  // User row copy sequencer
  typedef enum logic [1:0] {
    DPK_COPY_IDLE = 2'b00,
    DPK_COPY_RUN  = 2'b01,
    DPK_COPY_END  = 2'b10
  } dpk_copy_t;

  // Memory access request from the physical layer
  typedef struct packed {
    logic        req;
    logic        write;
    logic        isRam;
    logic [15:0] addr;
  } dpk_bus_req_t;

  // Control space access from the physical layer
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dpk_cs_req_t;

  // Whole block state
  typedef struct packed {
    logic [7:0]  linkCtlA;
    logic [7:0]  linkCtlB;
    logic [2:0]  errSig;
    logic [63:0] keyShift;
    logic [3:0]  keyCount;
    logic        keyErase;
    logic        keyNvm;
    logic        keyUrow;
    logic [7:0]  reset_request_field;
    logic [1:0]  clkSel;
    logic        clkHold;
    logic        urowFinal;
    logic        nvmSess;
    logic        urowSess;
    dpk_copy_t   copyState;
    logic [4:0]  copyIdx;
    logic [7:0]  rdData;
    logic        rdValid;
    logic        busGo;
    logic        busRefuse;
    logic        syncEvent;
  } dpk_state_t;

endpackage

`default_nettype wire
